// File: pcx_regs.svh
// Register map, field positions and reset values of the crossbar block
`ifndef PCX_REGS_SVH
`define PCX_REGS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define PCX_PORT0_ADDR 8'h80
`define PCX_PORT1_ADDR 8'h90
`define PCX_PORT2_ADDR 8'ha0
`define PCX_CFG0_ADDR  8'ha4
`define PCX_CFG1_ADDR  8'ha5
`define PCX_CFG2_ADDR  8'ha6
`define PCX_XBA_ADDR   8'he1
`define PCX_XBB_ADDR   8'he2
`define PCX_XBC_ADDR   8'he3

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PCX_XBA_SMB    0
`define PCX_XBA_SPI    1
`define PCX_XBA_UART   2
`define PCX_XBA_CEX_LO 3
`define PCX_XBA_CEX_HI 5
`define PCX_XBA_ECI    6
`define PCX_XBA_CP0    7
`define PCX_XBC_CNV    0
`define PCX_XBC_EN     6
`define PCX_XBC_WPD    7

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define PCX_XBC_WMASK  8'hc1
`define PCX_CEX_MAX    3'h5
`define PCX_PORT_RST   8'hff
`define PCX_CFG_RST    8'h00
`define PCX_XB_RST     8'h00
`define PCX_FORCE_OD   24'h00_0043

`endif

// File: pcx_pkg.sv
// Types shared by the crossbar block
package pcx_pkg;

	// ------------------------------------------------------------------
	// Register access request
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic       rd;
		logic       rmw;
		logic       wr;
		logic       bit_wr;
		logic [2:0] bit_idx;
		logic       bit_val;
		logic [7:0] wdata;
	} pcx_sfr_req_t;

	// ------------------------------------------------------------------
	// Pin drive bundle
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [23:0] o;
		logic [23:0] oe;
	} pcx_drive_t;

endpackage

// File: pcx_crossbar.sv
// Priority crossbar, port latches and pin drivers for three ports
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`include "pcx_regs.svh"

module pcx_crossbar
	import pcx_pkg::*;
#(
	parameter int NPORT = 3
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire pcx_sfr_req_t     sfr_req,
	output      logic [7:0]       sfr_rdata_r,
	input  wire logic [23:0]      fn_out,
	input  wire logic [23:0]      fn_oe,
	output      logic [23:0]      fn_in_r,
	input  wire logic [23:0]      pin_i,
	output      logic [23:0]      pin_o_r,
	output      logic [23:0]      pin_oe_r,
	output      logic             pullup_en_r
);

	localparam int NPIN = 8 * NPORT;
	localparam int NFN  = 24;
	// Named copy so the table can be indexed; a bare literal cannot be
	localparam logic [23:0] FORCE_OD = `PCX_FORCE_OD;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	// Returns {hit, index}
	function automatic logic [2:0] port_sel(input logic [7:0] a);
		if (a == `PCX_PORT0_ADDR) begin
			port_sel = 3'h4;
		end else if (a == `PCX_PORT1_ADDR) begin
			port_sel = 3'h5;
		end else if (a == `PCX_PORT2_ADDR) begin
			port_sel = 3'h6;
		end else begin
			port_sel = 3'h0;
		end
	endfunction

	function automatic logic [2:0] cfg_sel(input logic [7:0] a);
		if (a == `PCX_CFG0_ADDR) begin
			cfg_sel = 3'h4;
		end else if (a == `PCX_CFG1_ADDR) begin
			cfg_sel = 3'h5;
		end else if (a == `PCX_CFG2_ADDR) begin
			cfg_sel = 3'h6;
		end else begin
			cfg_sel = 3'h0;
		end
	endfunction

	logic [7:0]      latch_r [NPORT];
	logic [7:0]      cfg_r   [NPORT];
	logic [7:0]      xba_r;
	logic [7:0]      xbb_r;
	logic [7:0]      xbc_r;
	logic [23:0]     pin_q_r;
	logic [2:0]      pw;
	logic [2:0]      cw;
	logic [23:0]     latch_flat;
	logic [23:0]     cfg_flat;

	assign pw = port_sel(sfr_req.addr);
	assign cw = cfg_sel(sfr_req.addr);

	// ------------------------------------------------------------------
	// Port latches
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int p = 0; p < NPORT; p++) begin
				latch_r[p] <= `PCX_PORT_RST;
			end
		end else if (pw[2]) begin
			if (sfr_req.bit_wr) begin
				latch_r[pw[1:0]][sfr_req.bit_idx] <= sfr_req.bit_val;
			end else if (sfr_req.wr) begin
				latch_r[pw[1:0]] <= sfr_req.wdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Drive configuration
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int p = 0; p < NPORT; p++) begin
				cfg_r[p] <= `PCX_CFG_RST;
			end
		end else if (cw[2] && sfr_req.wr) begin
			cfg_r[cw[1:0]] <= sfr_req.wdata;
		end
	end

	// ------------------------------------------------------------------
	// Crossbar select registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			xba_r <= `PCX_XB_RST;
			xbb_r <= `PCX_XB_RST;
			xbc_r <= `PCX_XB_RST;
		end else if (sfr_req.wr) begin
			if (sfr_req.addr == `PCX_XBA_ADDR) begin
				xba_r <= sfr_req.wdata;
			end else if (sfr_req.addr == `PCX_XBB_ADDR) begin
				xbb_r <= sfr_req.wdata;
			end else if (sfr_req.addr == `PCX_XBC_ADDR) begin
				xbc_r <= sfr_req.wdata & `PCX_XBC_WMASK;
			end
		end
	end

	// ------------------------------------------------------------------
	// Pin sampling and flat views
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_q_r <= '0;
		end else begin
			pin_q_r <= pin_i;
		end
	end

	for (genvar p = 0; p < NPORT; p++) begin : g_flat
		assign latch_flat[8*p +: 8] = latch_r[p];
		assign cfg_flat[8*p +: 8]   = cfg_r[p];
	end

	// ------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------
	logic [7:0] rd_nxt;
	logic [2:0] pr;
	logic [2:0] cr;

	assign pr = port_sel(sfr_req.addr);
	assign cr = cfg_sel(sfr_req.addr);

	always_comb begin
		rd_nxt = 8'h00;
		if (pr[2]) begin
			if (sfr_req.rmw) begin
				rd_nxt = latch_r[pr[1:0]];
			end else begin
				rd_nxt = pin_q_r[8*pr[1:0] +: 8];
			end
		end else if (cr[2]) begin
			rd_nxt = cfg_r[cr[1:0]];
		end else if (sfr_req.addr == `PCX_XBA_ADDR) begin
			rd_nxt = xba_r;
		end else if (sfr_req.addr == `PCX_XBB_ADDR) begin
			rd_nxt = xbb_r;
		end else if (sfr_req.addr == `PCX_XBC_ADDR) begin
			rd_nxt = xbc_r;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sfr_rdata_r <= 8'h00;
		end else if (sfr_req.rd) begin
			sfr_rdata_r <= rd_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Function selection in priority order
	// ------------------------------------------------------------------
	// Order: SDA SCL, SPI x4, RX TX, CAPTURE_COMPARE_IO0..4, COUNTER_EXTERNAL_INPUT, CP0, CP1, T0,
	// EXT_IRQ0_IN, T1, EXT_IRQ1_IN, T2, TIMER2_EXT_IN, SYSCLK, CONV_START_INPUT
	logic        xbar_en;
	logic [2:0]  cex_n;
	logic [4:0]  cex_sel;
	logic [23:0] sel;

	assign xbar_en = xbc_r[`PCX_XBC_EN];
	assign cex_n   = xba_r[`PCX_XBA_CEX_HI:`PCX_XBA_CEX_LO];

	// Reserved counts route nothing rather than guess a width
	for (genvar k = 0; k < 5; k++) begin : g_cex
		assign cex_sel[k] = (cex_n <= `PCX_CEX_MAX) &&
			(cex_n > 3'(k));
	end

	always_comb begin
		sel = {
			xbc_r[`PCX_XBC_CNV],
			xbb_r[7], xbb_r[6], xbb_r[5], xbb_r[4],
			xbb_r[3], xbb_r[2], xbb_r[1], xbb_r[0],
			xba_r[`PCX_XBA_CP0],
			xba_r[`PCX_XBA_ECI],
			cex_sel,
			{2{xba_r[`PCX_XBA_UART]}},
			{4{xba_r[`PCX_XBA_SPI]}},
			{2{xba_r[`PCX_XBA_SMB]}}
		};
		if (!xbar_en) begin
			sel = '0;
		end
	end

	// ------------------------------------------------------------------
	// Slot assignment
	// ------------------------------------------------------------------
	logic [5:0]  cnt;
	logic [23:0] used;
	logic [4:0]  src    [NPIN];
	logic [23:0] fn_map;
	logic [4:0]  fn_pin [NFN];

	always_comb begin
		cnt    = '0;
		used   = '0;
		fn_map = '0;
		for (int p = 0; p < NPIN; p++) begin
			src[p] = '0;
		end
		for (int i = 0; i < NFN; i++) begin
			fn_pin[i] = '0;
			if (sel[i]) begin
				// A lower function takes the next free slot
				if (cnt < 6'(NPIN)) begin
					used[cnt[4:0]] = 1'b1;
					src[cnt[4:0]]  = 5'(i);
					fn_map[i]      = 1'b1;
					fn_pin[i]      = cnt[4:0];
				end
				cnt = cnt + 6'h01;
			end
		end
	end

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------
	pcx_drive_t drv_nxt;

	always_comb begin
		logic val;
		logic en;
		logic od;
		val = 1'b0;
		en  = 1'b0;
		od  = 1'b0;
		drv_nxt = '0;
		for (int p = 0; p < NPIN; p++) begin
			if (used[p]) begin
				val = fn_out[src[p]];
				en  = fn_oe[src[p]];
				od  = ~cfg_flat[p] |
					FORCE_OD[src[p]];
			end else begin
				val = latch_flat[p];
				en  = 1'b1;
				od  = ~cfg_flat[p];
			end
			if (!xbar_en) begin
				drv_nxt.o[p]  = 1'b0;
				drv_nxt.oe[p] = 1'b0;
			end else if (od) begin
				// Open-drain only pulls low; a 1 leaves the pin floating
				drv_nxt.o[p]  = 1'b0;
				drv_nxt.oe[p] = en & ~val;
			end else begin
				drv_nxt.o[p]  = val;
				drv_nxt.oe[p] = en;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_o_r  <= '0;
			pin_oe_r <= '0;
		end else begin
			pin_o_r  <= drv_nxt.o;
			pin_oe_r <= drv_nxt.oe;
		end
	end

	// ------------------------------------------------------------------
	// Pull-ups
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pullup_en_r <= 1'b1;
		end else begin
			pullup_en_r <= ~xbc_r[`PCX_XBC_WPD];
		end
	end

	// ------------------------------------------------------------------
	// Function inputs
	// ------------------------------------------------------------------
	logic [23:0] fin_nxt;

	always_comb begin
		fin_nxt = '0;
		for (int i = 0; i < NFN; i++) begin
			if (fn_map[i]) begin
				fin_nxt[i] = pin_q_r[fn_pin[i]];
			end else begin
				fin_nxt[i] = latch_flat[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fn_in_r <= '0;
		end else begin
			fn_in_r <= fin_nxt;
		end
	end

endmodule

// File: pcx_crossbar_properties.sv
// Port-level assertions for the crossbar block
`include "pcx_regs.svh"

module pcx_crossbar_properties
	import pcx_pkg::*;
#(
	parameter int NPORT = 3
) (
	input wire logic         clk,
	input wire logic         sys_rst,
	input wire pcx_sfr_req_t sfr_req,
	input wire logic [7:0]   sfr_rdata_r,
	input wire logic [23:0]  fn_out,
	input wire logic [23:0]  fn_oe,
	input wire logic [23:0]  fn_in_r,
	input wire logic [23:0]  pin_i,
	input wire logic [23:0]  pin_o_r,
	input wire logic [23:0]  pin_oe_r,
	input wire logic         pullup_en_r
);
	// ------
	// Shadow state
	// ------
	logic [7:0] xa_r;
	logic [7:0] p0_r;
	logic       en_r;
	wire  [7:0] a = sfr_req.addr;
	wire        w = sfr_req.wr && !sfr_req.bit_wr;
	wire        r = sfr_req.rd;
	wire  [7:0] p0_pins = pin_i[7:0];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			xa_r <= 8'h00;
			en_r <= 1'b0;
			p0_r <= 8'hff;
		end else begin
			if (w && a == `PCX_XBA_ADDR) xa_r <= sfr_req.wdata;
			if (w && a == `PCX_XBC_ADDR) en_r <= sfr_req.wdata[6];
			if (w && a == `PCX_PORT0_ADDR) p0_r <= sfr_req.wdata;
			if (sfr_req.bit_wr && a == `PCX_PORT0_ADDR)
				p0_r[sfr_req.bit_idx] <= sfr_req.bit_val;
		end
	end

	// ------
	// Assertions
	// ------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	off_idle_a: assert property (!$past(en_r) |-> pin_oe_r == 24'h00_0000)
		else $error("pins driven while crossbar off");
	// Reset edge guard: pin registers clear while the shadow may still be set
	smb_od_a: assert property (!$past(sys_rst) && $past(en_r && xa_r[0])
		|-> pin_o_r[1:0] == 2'h0 && pin_oe_r[1:0] == $past(fn_oe[1:0] & ~fn_out[1:0]))
		else $error("bus pins not open drain");
	pull_off_a: assert property (w && a == `PCX_XBC_ADDR && sfr_req.wdata[7]
		|-> ##[1:2] !pullup_en_r) else $error("pull-ups still on");
	xbc_zero_a: assert property (r && a == `PCX_XBC_ADDR |=> sfr_rdata_r[5:1] == 5'h00)
		else $error("unused bits not zero");
	en_back_a: assert property (r && a == `PCX_XBC_ADDR |=> sfr_rdata_r[6] == $past(en_r))
		else $error("enable bit readback wrong");
	sel_back_a: assert property (r && a == `PCX_XBA_ADDR |=> sfr_rdata_r == $past(xa_r))
		else $error("select readback wrong");
	p0_rmw_a: assert property (r && sfr_req.rmw && a == `PCX_PORT0_ADDR
		|=> sfr_rdata_r == $past(p0_r)) else $error("rmw read not latch");
	p0_pin_a: assert property (r && !sfr_req.rmw && a == `PCX_PORT0_ADDR
		|=> sfr_rdata_r == $past(p0_pins, 2)) else $error("port read not pins");

	cover property (en_r && xa_r[0]);
	cover property (r && sfr_req.rmw);
	cover property (!pullup_en_r);
endmodule

// File: pcx_pin_model.sv
// External circuitry on the 24 port pins
module pcx_pin_model (
	input  wire logic        clk,
	input  wire logic [23:0] o,
	input  wire logic [23:0] oe,
	input  wire logic        pullup_en,
	input  wire logic [23:0] ext_en,
	input  wire logic [23:0] ext_v,
	output      logic [23:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Unpulled floating pins toggle so a stale level never passes
	logic [23:0] flt_r = 24'h00_0000;
	always @(posedge clk) flt_r <= ~flt_r;
	assign pin = (oe & o) | (~oe & ext_en & ext_v)
		| (~oe & ~ext_en & (pullup_en ? 24'hff_ffff : flt_r));
endmodule

// File: pcx_crossbar_bench.sv
// Self-checking bench for the crossbar block
`include "pcx_regs.svh"
module pcx_crossbar_bench
	import pcx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic         clk = 1'b0;
	logic         sys_rst = 1'b1;
	pcx_sfr_req_t rq = '0;
	logic [23:0]  fn_out = 24'ha5_3cd6;
	logic [23:0]  fn_oe = 24'hff_f0ff;
	logic [23:0]  ext_en = 24'h00_0000;
	logic [23:0]  ext_v = 24'h00_0000;
	logic [23:0]  pin_i, pin_o_r, pin_oe_r, fn_in_r, eo, eoe, ein, lat, cfg;
	logic [7:0]   sfr_rdata_r, xa, xb, xc;
	logic         pullup_en_r;
	int           n_errors = 0;
	int           samples_checked = 0;
	int           cyc = 0;

	pcx_crossbar pcx_crossbar_i (.clk(clk), .sys_rst(sys_rst), .sfr_req(rq),
		.sfr_rdata_r(sfr_rdata_r), .fn_out(fn_out), .fn_oe(fn_oe),
		.fn_in_r(fn_in_r), .pin_i(pin_i), .pin_o_r(pin_o_r),
		.pin_oe_r(pin_oe_r), .pullup_en_r(pullup_en_r));
	pcx_pin_model pcx_pin_model_i (.clk(clk), .o(pin_o_r), .oe(pin_oe_r),
		.pullup_en(pullup_en_r), .ext_en(ext_en), .ext_v(ext_v), .pin(pin_i));

	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			conclude();
		end
	end

	task conclude();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Kinds: 0 write, 1 read, 2 rmw read, 3 bit write (d[2:0] bit, d[3] value)
	task acc(input logic [7:0] a, input int k, input logic [7:0] d);
		@(posedge clk) #5;
		rq = '0;
		rq.addr = a;
		rq.wdata = d;
		rq.wr = (k == 0);
		rq.rd = (k == 1 || k == 2);
		rq.rmw = (k == 2);
		rq.bit_wr = (k == 3);
		rq.bit_idx = d[2:0];
		rq.bit_val = d[3];
		@(posedge clk) #5;
		rq = '0;
	endtask

	task rdc(input logic [7:0] a, input int k, input logic [7:0] e);
		acc(a, k, 8'h00);
		chk(24'(sfr_rdata_r), 24'(e));
	endtask

	task automatic model();
		logic [23:0] sel;
		logic        od;
		int          p;
		sel = {xc[0], xb, xa[7:6], 5'h00, {2{xa[2]}}, {4{xa[1]}}, {2{xa[0]}}};
		for (int k = 0; k < 5; k++)
			sel[8 + k] = (xa[5:3] > k) && (xa[5:3] < 3'h6);
		p = 0;
		eo = '0;
		eoe = '0;
		ein = lat;
		for (int f = 0; f < 24; f++) if (sel[f]) begin
			od = !cfg[p] || f < 2 || f == 6;
			eo[p] = !od && fn_out[f];
			eoe[p] = fn_oe[f] && !(od && fn_out[f]);
			ein[f] = pin_i[p];
			p++;
		end
		for (int q = p; q < 24; q++) begin
			eo[q] = cfg[q] && lat[q];
			eoe[q] = cfg[q] || !lat[q];
		end
		if (!xc[6]) eoe = '0;
	endtask

	task cfgx(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		xa = a;
		xb = b;
		xc = c;
		acc(`PCX_XBA_ADDR, 0, a);
		acc(`PCX_XBB_ADDR, 0, b);
		acc(`PCX_XBC_ADDR, 0, c);
		repeat (4) @(posedge clk);
		#5 model();
		chk(pin_oe_r, eoe);
		chk(pin_o_r & eoe, eo & eoe);
		if (c[6]) chk(fn_in_r, ein);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		#5 sys_rst = 1'b0;
		rdc(`PCX_XBA_ADDR, 1, 8'h00);
		rdc(`PCX_XBB_ADDR, 1, 8'h00);
		rdc(`PCX_CFG0_ADDR, 1, 8'h00);
		rdc(`PCX_PORT0_ADDR, 2, 8'hff);
		rdc(`PCX_PORT1_ADDR, 2, 8'hff);
		rdc(`PCX_PORT2_ADDR, 2, 8'hff);
		rdc(8'h55, 1, 8'h00);
		chk(24'(pullup_en_r), 24'h00_0001);
		$display("reset test done");
		acc(`PCX_XBA_ADDR, 0, 8'h11);
		acc(`PCX_XBC_ADDR, 0, 8'hbf);
		rdc(`PCX_XBC_ADDR, 1, 8'h81);
		chk(pin_oe_r, 24'h00_0000);
		chk(24'(pullup_en_r), 24'h00_0000);
		$display("disabled test done");
		lat = 24'h3c_5a96;
		cfg = 24'h0f_fff3;
		acc(`PCX_PORT0_ADDR, 0, 8'h96);
		acc(`PCX_PORT1_ADDR, 0, 8'h5a);
		acc(`PCX_PORT2_ADDR, 0, 8'h3c);
		acc(`PCX_CFG0_ADDR, 0, 8'hf3);
		acc(`PCX_CFG1_ADDR, 0, 8'hff);
		acc(`PCX_CFG2_ADDR, 0, 8'h0f);
		for (int i = 0; i < 8; i++)
			cfgx({2'b00, 3'(i), 3'b101}, 8'h00, 8'h40);
		cfgx(8'h11, 8'h00, 8'h40);
		cfgx(8'h80, 8'h04, 8'h41);
		cfgx(8'hc6, 8'hff, 8'h41);
		cfgx(8'hef, 8'hff, 8'h41);
		$display("mapping test done");
		ext_en = 24'h00_00ff;
		ext_v = 24'h00_003c;
		// Release every pin so only the external drivers set port 0
		acc(`PCX_XBC_ADDR, 0, 8'h00);
		acc(`PCX_CFG0_ADDR, 0, 8'h00);
		acc(`PCX_PORT0_ADDR, 0, 8'hff);
		repeat (3) @(posedge clk);
		rdc(`PCX_PORT0_ADDR, 1, 8'h3c);
		rdc(`PCX_PORT0_ADDR, 2, 8'hff);
		acc(`PCX_PORT0_ADDR, 3, 8'h02);
		rdc(`PCX_PORT0_ADDR, 2, 8'hfb);
		acc(`PCX_XBA_ADDR, 3, 8'h0b);
		rdc(`PCX_XBA_ADDR, 1, 8'hef);
		$display("port test done");
		conclude();
	end
endmodule

bind pcx_crossbar pcx_crossbar_properties #(.NPORT(NPORT))
	pcx_crossbar_properties_i (.clk(clk), .sys_rst(sys_rst),
	.sfr_req(sfr_req), .sfr_rdata_r(sfr_rdata_r), .fn_out(fn_out),
	.fn_oe(fn_oe), .fn_in_r(fn_in_r), .pin_i(pin_i), .pin_o_r(pin_o_r),
	.pin_oe_r(pin_oe_r), .pullup_en_r(pullup_en_r));
